// ==== hdl/timer_chan0_io_select.v ====
// Channel 0 pin role selection with capture/compare on general registers B and D
// Functional notes
// RULE1 - Bits 7:4 of the low role register select register D role; reset zero.
// RULE2 - Bits 3:0 of the low role register select register C role; reset zero.
// RULE3 - Top bit clear means compare; low bits 00 disable pin; bit2 clear starts low.
// RULE4 - Compare codes with bit 2 set and nonzero low bits start the pin high.
// RULE5 - Low bits 01 drive the pin low on compare match.
// RULE6 - Low bits 10 drive the pin high on compare match.
// RULE7 - Low bits 11 invert the pin on every compare match.
// RULE8 - Codes 10xx make register B capture from channel 0 pin B.
// RULE9 - Code 1000 captures on a rising pin edge.
// RULE10 - Code 1001 captures on a falling pin edge.
// RULE11 - Code 101x captures on both pin edges.
// RULE12 - Codes 11xx for B capture on each channel 1 counter count.
// RULE13 - Channel 1 prescale 000 makes codes 11xx capture nothing in B or D.
// RULE14 - Register D uses the same encodings, capturing from channel 0 pin D.
// RULE15 - Register D codes 11xx capture on each channel 1 counter count.
// RULE16 - With buffer B enabled, register D raises no capture or compare events.
// RULE17 - Initial pin level applies only while the counter start bit is clear.
// RULE18 - Buffer B enable pairs B and D; clear lets B work alone.
// RULE19 - Capture copies the counter; match when counter equals the register.
`timescale 1ns/1ps
`include "timer_chan0_defs.vh"

module timer_chan0_io_select #(
  parameter CNT_W = 16,
  parameter ADR_W = 6
) (
  input  wire             REF_CLK_I,     // 125 MHz peripheral clock
  input  wire             SRST_I,        // Synchronous reset, active high
  input  wire [ADR_W-1:0] ADDR_I,        // Register byte address
  input  wire [15:0]      WDATA_I,       // Register write data
  input  wire             WR_I,          // Write strobe
  input  wire             RD_I,          // Read strobe
  output wire [15:0]      RDATA_O,       // Read data, cycle after strobe
  input  wire [CNT_W-1:0] CNT_I,         // Channel 0 counter value
  input  wire             CH1_COUNT_I,   // Channel 1 counter counted
  output wire             START_O,       // Counter start bit to counter
  output wire [2:0]       CH1_PSC_O,     // Channel 1 prescale select
  input  wire             PIN_B_I,       // Channel 0 pin B level
  output wire             PIN_B_O,       // Pin B drive level
  output wire             PIN_B_OE_N_O,  // Pin B enable, low drives
  input  wire             PIN_D_I,       // Channel 0 pin D level
  output wire             PIN_D_O,       // Pin D drive level
  output wire             PIN_D_OE_N_O,  // Pin D enable, low drives
  output wire [3:0]       ROLE_C_O,      // Register C role field
  output wire             IRQ_O          // Level interrupt
);

  // ==========================================================
  // Registers
  reg  [7:0]       role_low_q;
  reg  [7:0]       role_high_q;
  reg  [7:0]       mode_q;
  reg              start_q;
  reg  [2:0]       psc_q;
  reg  [CNT_W-1:0] gr_c_q;
  reg  [`ST_W-1:0] status_q;
  reg  [`ST_W-1:0] mask_q;
  reg  [15:0]      rdata_q;
  reg  [15:0]      rdata_d;
  reg  [1:0]       sync_b_q;
  reg  [1:0]       sync_d_q;

  wire [CNT_W-1:0] gr_b;
  wire [CNT_W-1:0] gr_d;
  wire             buf_b;
  wire             count_evt;
  wire             cap_b;
  wire             cap_d;
  wire             match_b;
  wire             match_d;
  wire [`ST_W-1:0] events;

  // Decode used by every write-enable
  function wr_hit;
    input [ADR_W-1:0] a;
    input [ADR_W-1:0] ofs;
    input             wr;
    begin
      wr_hit = wr & (a == ofs);
    end
  endfunction

  assign buf_b = mode_q[`BUF_B_BIT]; // RULE18

  // Undivided channel 1 clock would capture every cycle; the mode is void
  assign count_evt = CH1_COUNT_I & (psc_q != `PSC_UNDIVIDED); // RULE13

  // ==========================================================
  // Pin synchronisers
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      sync_b_q <= 2'h0;
      sync_d_q <= 2'h0;
    end else begin
      sync_b_q <= {sync_b_q[0], PIN_B_I};
      sync_d_q <= {sync_d_q[0], PIN_D_I};
    end
  end

  // ==========================================================
  // Software register writes
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      role_low_q  <= `ROLE_RST; // RULE1 RULE2
      role_high_q <= `ROLE_RST;
      mode_q      <= `MODE_RST;
      start_q     <= 1'b0;
      psc_q       <= `PSC_RST;
      gr_c_q      <= {CNT_W{1'b0}};
      mask_q      <= `ST_RST;
    end else begin
      if (wr_hit(ADDR_I, `OFS_ROLE_LOW, WR_I))
        role_low_q <= WDATA_I[7:0]; // RULE1 RULE2
      if (wr_hit(ADDR_I, `OFS_ROLE_HIGH, WR_I))
        role_high_q <= WDATA_I[7:0];
      if (wr_hit(ADDR_I, `OFS_MODE, WR_I))
        mode_q <= WDATA_I[7:0];
      if (wr_hit(ADDR_I, `OFS_START, WR_I))
        start_q <= WDATA_I[`START_BIT];
      if (wr_hit(ADDR_I, `OFS_CH1_CTRL, WR_I))
        psc_q <= WDATA_I[`PSC_HI:`PSC_LO];
      if (wr_hit(ADDR_I, `OFS_GR_C, WR_I))
        gr_c_q <= WDATA_I[CNT_W-1:0];
      if (wr_hit(ADDR_I, `OFS_MASK, WR_I))
        mask_q <= WDATA_I[`ST_W-1:0];
    end
  end

  // ==========================================================
  // General registers B and D
  // Buffer pairing: B capture pushes old B into D, B match reloads B from D
  timer_gr_unit #(
    .W (CNT_W)
  ) u_gr_b (
    .clk_i       (REF_CLK_I),
    .srst_i      (SRST_I),
    .role_i      (role_high_q[`ROLE_B_HI:`ROLE_B_LO]),
    .inhibit_i   (1'b0),
    .start_i     (start_q),
    .cnt_i       (CNT_I),
    .pin_lvl_i   (sync_b_q[1]),
    .count_evt_i (count_evt),
    .sw_wr_i     (wr_hit(ADDR_I, `OFS_GR_B, WR_I)),
    .sw_data_i   (WDATA_I[CNT_W-1:0]),
    .ld_i        (buf_b & match_b), // RULE18
    .ld_data_i   (gr_d),
    .gr_o        (gr_b),
    .pin_out_o   (PIN_B_O),
    .pin_oe_n_o  (PIN_B_OE_N_O),
    .cap_o       (cap_b),
    .match_o     (match_b)
  );

  timer_gr_unit #(
    .W (CNT_W)
  ) u_gr_d (
    .clk_i       (REF_CLK_I),
    .srst_i      (SRST_I),
    .role_i      (role_low_q[`ROLE_D_HI:`ROLE_D_LO]), // RULE14
    .inhibit_i   (buf_b),                             // RULE16
    .start_i     (start_q),
    .cnt_i       (CNT_I),
    .pin_lvl_i   (sync_d_q[1]),
    .count_evt_i (count_evt),
    .sw_wr_i     (wr_hit(ADDR_I, `OFS_GR_D, WR_I)),
    .sw_data_i   (WDATA_I[CNT_W-1:0]),
    .ld_i        (buf_b & cap_b), // RULE18
    .ld_data_i   (gr_b),
    .gr_o        (gr_d),
    .pin_out_o   (PIN_D_O),
    .pin_oe_n_o  (PIN_D_OE_N_O),
    .cap_o       (cap_d),
    .match_o     (match_d)
  );

  // ==========================================================
  // Interrupt status: set wins over write-one-to-clear
  assign events = {match_d, cap_d, match_b, cap_b};

  always @(posedge REF_CLK_I) begin
    if (SRST_I)
      status_q <= `ST_RST;
    else if (wr_hit(ADDR_I, `OFS_STATUS, WR_I))
      status_q <= (status_q & ~WDATA_I[`ST_W-1:0]) | events;
    else
      status_q <= status_q | events;
  end

  assign IRQ_O = |(status_q & mask_q);

  // ==========================================================
  // Read path, registered; unmapped addresses read zero
  always @* begin
    rdata_d = 16'h0000;
    case (ADDR_I)
      `OFS_ROLE_LOW:  rdata_d[7:0] = role_low_q;
      `OFS_ROLE_HIGH: rdata_d[7:0] = role_high_q;
      `OFS_MODE:      rdata_d[7:0] = mode_q;
      `OFS_START:     rdata_d[`START_BIT] = start_q;
      `OFS_CH1_CTRL:  rdata_d[`PSC_HI:`PSC_LO] = psc_q;
      `OFS_GR_B:      rdata_d[CNT_W-1:0] = gr_b;
      `OFS_GR_C:      rdata_d[CNT_W-1:0] = gr_c_q;
      `OFS_GR_D:      rdata_d[CNT_W-1:0] = gr_d;
      `OFS_STATUS:    rdata_d[`ST_W-1:0] = status_q;
      `OFS_MASK:      rdata_d[`ST_W-1:0] = mask_q;
      default:        rdata_d = 16'h0000;
    endcase
  end

  always @(posedge REF_CLK_I) begin
    if (SRST_I)
      rdata_q <= 16'h0000;
    else if (RD_I)
      rdata_q <= rdata_d;
    else
      rdata_q <= 16'h0000;
  end

  assign RDATA_O   = rdata_q;
  assign START_O   = start_q;
  assign CH1_PSC_O = psc_q;
  assign ROLE_C_O  = role_low_q[`ROLE_C_HI:`ROLE_C_LO]; // RULE2

endmodule

// ==== hdl/timer_chan0_defs.vh ====
// Constants for the channel 0 pin role and capture/compare block
`ifndef TIMER_CHAN0_DEFS_VH
`define TIMER_CHAN0_DEFS_VH

// ==========================================================
// Register byte offsets
`define OFS_ROLE_LOW      6'h00
`define OFS_ROLE_HIGH     6'h04
`define OFS_MODE          6'h08
`define OFS_START         6'h0c
`define OFS_CH1_CTRL      6'h10
`define OFS_GR_B          6'h14
`define OFS_GR_C          6'h18
`define OFS_GR_D          6'h1c
`define OFS_STATUS        6'h20
`define OFS_MASK          6'h24

// ==========================================================
// Field positions
`define ROLE_D_HI         7
`define ROLE_D_LO         4
`define ROLE_C_HI         3
`define ROLE_C_LO         0
`define ROLE_B_HI         7
`define ROLE_B_LO         4
`define BUF_B_BIT         5
`define START_BIT         0
`define PSC_HI            2
`define PSC_LO            0
`define ST_CAP_B          0
`define ST_MATCH_B        1
`define ST_CAP_D          2
`define ST_MATCH_D        3
`define ST_W              4

// ==========================================================
// Reset values and encodings
`define ROLE_RST          8'h00
`define MODE_RST          8'h00
`define PSC_RST           3'h0
`define PSC_UNDIVIDED     3'h0
`define ST_RST            4'h0
`define ROLE_IC_BIT       3
`define ROLE_INIT_BIT     2
`define ROLE_EDGE_BOTH    1
`define ROLE_EDGE_FALL    0
`define ACT_OFF           2'h0
`define ACT_LOW           2'h1
`define ACT_HIGH          2'h2
`define ACT_TOGGLE        2'h3
`define SRC_PIN           2'h2
`define SRC_CH1           2'h3

`endif

// ==== hdl/timer_gr_unit.v ====
// One general register with its pin role decode, capture and compare logic
`timescale 1ns/1ps
`include "timer_chan0_defs.vh"

module timer_gr_unit #(
  parameter W = 16
) (
  input  wire         clk_i,       // Peripheral clock
  input  wire         srst_i,      // Synchronous reset, active high
  input  wire [3:0]   role_i,      // Role field of this register
  input  wire         inhibit_i,   // Register used as buffer: no events
  input  wire         start_i,     // Counter running
  input  wire [W-1:0] cnt_i,       // Channel counter value
  input  wire         pin_lvl_i,   // Synchronised pin level
  input  wire         count_evt_i, // Qualified channel 1 count event
  input  wire         sw_wr_i,     // Software write of the register
  input  wire [W-1:0] sw_data_i,   // Software write data
  input  wire         ld_i,        // Buffer transfer into the register
  input  wire [W-1:0] ld_data_i,   // Buffer transfer data
  output wire [W-1:0] gr_o,        // General register value
  output wire         pin_out_o,   // Pin output level
  output wire         pin_oe_n_o,  // Pin output enable, low drives
  output wire         cap_o,       // Capture pulse
  output wire         match_o      // Compare match pulse
);

  reg  [W-1:0] gr_q;
  reg          pin_q;
  reg          pin_prev_q;
  reg          eq_q;
  reg          edge_sel;
  wire         is_ic;
  wire         oc_act;
  wire         rise;
  wire         fall;
  wire         eq;

  // ==========================================================
  // Role decode
  assign is_ic  = role_i[`ROLE_IC_BIT];
  assign oc_act = ~is_ic & (role_i[1:0] != `ACT_OFF) & ~inhibit_i; // RULE3 RULE16
  assign rise   = pin_lvl_i & ~pin_prev_q;
  assign fall   = ~pin_lvl_i & pin_prev_q;

  always @* begin
    case (role_i[3:2])
      `SRC_PIN: begin
        if (role_i[`ROLE_EDGE_BOTH])
          edge_sel = rise | fall;   // RULE11
        else if (role_i[`ROLE_EDGE_FALL])
          edge_sel = fall;          // RULE10
        else
          edge_sel = rise;          // RULE9
      end
      `SRC_CH1: edge_sel = count_evt_i; // RULE12 RULE15
      default:  edge_sel = 1'b0;
    endcase
  end

  assign cap_o = is_ic & ~inhibit_i & edge_sel; // RULE8 RULE14 RULE16

  // Match fires once on entering equality, so a stalled counter does not retoggle
  assign eq      = (cnt_i == gr_q);
  assign match_o = oc_act & start_i & eq & ~eq_q; // RULE19

  // ==========================================================
  // State
  always @(posedge clk_i) begin
    if (srst_i) begin
      gr_q       <= {W{1'b0}};
      pin_q      <= 1'b0;
      pin_prev_q <= 1'b0;
      eq_q       <= 1'b0;
    end else begin
      pin_prev_q <= pin_lvl_i;
      eq_q       <= eq;
      // Capture wins over a software write in the same cycle
      if (cap_o)
        gr_q <= cnt_i;               // RULE19
      else if (sw_wr_i)
        gr_q <= sw_data_i;
      else if (ld_i)
        gr_q <= ld_data_i;
      if (!start_i)
        pin_q <= role_i[`ROLE_INIT_BIT]; // RULE3 RULE4 RULE17
      else if (match_o) begin
        case (role_i[1:0])
          `ACT_LOW:    pin_q <= 1'b0;   // RULE5
          `ACT_HIGH:   pin_q <= 1'b1;   // RULE6
          `ACT_TOGGLE: pin_q <= ~pin_q; // RULE7
          default:     pin_q <= pin_q;
        endcase
      end
    end
  end

  assign gr_o       = gr_q;
  assign pin_out_o  = pin_q;
  assign pin_oe_n_o = ~oc_act; // RULE3

endmodule

// ==== test/timer_chan0_io_select_sva.sv ====
// Checker for the channel 0 pin role block
`timescale 1ns/1ps
module timer_chan0_io_select_sva #(
  parameter CNT_W = 16,
  parameter ADR_W = 6
) (
  input wire             REF_CLK_I,    // Clock
  input wire             SRST_I,       // Reset
  input wire [ADR_W-1:0] ADDR_I,       // Address
  input wire [15:0]      WDATA_I,      // Write data
  input wire             WR_I,         // Write
  input wire             RD_I,         // Read
  input wire [15:0]      RDATA_O,      // Read data
  input wire [CNT_W-1:0] CNT_I,        // Counter
  input wire             START_O,      // Start
  input wire             PIN_B_O,      // Pin B level
  input wire             PIN_B_OE_N_O, // Pin B enable
  input wire             PIN_D_O,      // Pin D level
  input wire             PIN_D_OE_N_O, // Pin D enable
  input wire [3:0]       ROLE_C_O,     // Role C
  input wire             IRQ_O         // Interrupt
);
  // ====
  // Shadows of role, mode and register B, kept from the bus writes
  reg [3:0]       bq, dq;
  reg             bf;
  reg [CNT_W-1:0] grb;
  wire            eq = CNT_I == grb;
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      bq  <= 4'h0;
      dq  <= 4'h0;
      bf  <= 1'b0;
      grb <= {CNT_W{1'b0}};
    end else if (WR_I) begin
      case (ADDR_I)
        6'h00: dq <= WDATA_I[7:4];
        6'h04: bq <= WDATA_I[7:4];
        6'h08: bf <= WDATA_I[5];
        6'h14: grb <= WDATA_I[CNT_W-1:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  property p_rd_low;
    RD_I && ADDR_I == 6'h00 |=> RDATA_O == {8'h00, $past(dq), $past(ROLE_C_O)};
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("role byte read wrong");
  property p_role_c;
    WR_I && ADDR_I == 6'h00 |=> ROLE_C_O == $past(WDATA_I[3:0]);
  endproperty
  a_role_c: assert property (p_role_c) else $error("role C not written");
  property p_oe_b;
    PIN_B_OE_N_O == (bq[3] || bq[1:0] == 2'h0);
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin B enable wrong");
  property p_oe_d;
    PIN_D_OE_N_O == (bf || dq[3] || dq[1:0] == 2'h0);
  endproperty
  a_oe_d: assert property (p_oe_d) else $error("pin D enable wrong");
  property p_init_b;
    !START_O && !bq[3] && bq[1:0] != 2'h0 |=> PIN_B_O == $past(bq[2]);
  endproperty
  a_init_b: assert property (p_init_b) else $error("pin B initial level wrong");
  property p_init_d;
    !START_O && !bf && !dq[3] && dq[1:0] != 2'h0 |=> PIN_D_O == $past(dq[2]);
  endproperty
  a_init_d: assert property (p_init_d) else $error("pin D initial level wrong");
  property p_set_b;
    START_O && !bq[3] && (bq[1] ^ bq[0]) && $rose(eq) |-> ##2 PIN_B_O == bq[1];
  endproperty
  a_set_b: assert property (p_set_b) else $error("pin B match level wrong");
  property p_tog_b;
    START_O && !bq[3] && bq[1:0] == 2'h3 && $rose(eq) |-> ##[1:2] $changed(PIN_B_O);
  endproperty
  a_tog_b: assert property (p_tog_b) else $error("pin B did not toggle");
  c_match: cover property (START_O && $rose(eq));
  c_read: cover property (RD_I && ADDR_I == 6'h00);
  c_irq: cover property ($rose(IRQ_O));
endmodule

bind timer_chan0_io_select timer_chan0_io_select_sva #(.CNT_W(CNT_W), .ADR_W(ADR_W)) i_timer_chan0_io_select_sva (
  .REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .CNT_I(CNT_I), .START_O(START_O), .PIN_B_O(PIN_B_O),
  .PIN_B_OE_N_O(PIN_B_OE_N_O), .PIN_D_O(PIN_D_O), .PIN_D_OE_N_O(PIN_D_OE_N_O),
  .ROLE_C_O(ROLE_C_O), .IRQ_O(IRQ_O));

// ==== test/chan0_pin_model.sv ====
// Model of one channel 0 timer pin and its outside driver
`timescale 1ns/1ps
module chan0_pin_model (
  input  wire clk_i,     // Clock
  input  wire ext_en_i,  // Outside driver on
  input  wire ext_lvl_i, // Outside level
  input  wire out_i,     // Block drive level
  input  wire oe_n_i,    // Block enable, low drives
  output wire pin_o      // Resolved pin level
);
  // ====
  // A floating pin shows a level that changes every cycle, not a stale one
  reg wobble_q = 1'b0;
  always @(posedge clk_i) wobble_q <= ~wobble_q;
  assign pin_o = !oe_n_i ? out_i : (ext_en_i ? ext_lvl_i : wobble_q);
endmodule

// ==== test/timer_chan0_io_select_bench.sv ====
// Self-checking bench for the channel 0 pin role block
`timescale 1ns/1ps
module timer_chan0_io_select_bench;
  // ====
  // Stimulus and observation
  reg         clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, ch1 = 1'b0;
  reg         ext_en = 1'b0, lvl_b = 1'b0, lvl_d = 1'b0;
  reg  [5:0]  addr = 6'h00;
  reg  [15:0] wdata = 16'h0000, cnt = 16'h0000, got;
  reg  [31:0] r;
  reg  [3:0]  c;
  wire [15:0] rdata;
  wire [3:0]  role_c;
  wire [2:0]  psc;
  wire        st, pb_o, pb_oe_n, pd_o, pd_oe_n, pin_b, pin_d, irq;
  integer     miscompares = 0, n_checks = 0, cycles = 0, seed = 15, i;
  always #4 clk = ~clk;
  timer_chan0_io_select i_timer_chan0_io_select (
    .REF_CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .CNT_I(cnt), .CH1_COUNT_I(ch1), .START_O(st), .CH1_PSC_O(psc),
    .PIN_B_I(pin_b), .PIN_B_O(pb_o), .PIN_B_OE_N_O(pb_oe_n), .PIN_D_I(pin_d), .PIN_D_O(pd_o),
    .PIN_D_OE_N_O(pd_oe_n), .ROLE_C_O(role_c), .IRQ_O(irq));
  chan0_pin_model i_pin_b (.clk_i(clk), .ext_en_i(ext_en), .ext_lvl_i(lvl_b), .out_i(pb_o),
    .oe_n_i(pb_oe_n), .pin_o(pin_b));
  chan0_pin_model i_pin_d (.clk_i(clk), .ext_en_i(ext_en), .ext_lvl_i(lvl_d), .out_i(pd_o),
    .oe_n_i(pd_oe_n), .pin_o(pin_d));
  task tally_and_finish;
    begin
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  task chk(input [15:0] g, input [15:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr_reg(input [5:0] a, input [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [5:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      got = rdata;
    end
  endtask
  // Ends off the edge, so only checks and bus tasks may follow it
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      @(negedge clk);
    end
  endtask
  function exp_pin(input [3:0] code);
    exp_pin = (code[1:0] == 2'h3) ? ~code[2] : code[1];
  endfunction
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd_reg(6'h00);
    chk(got, 16'h0000);
    for (i = 0; i < 6; i = i + 1) begin
      r = $random(seed);
      wr_reg(6'h00, r[15:0]);
      rd_reg(6'h00);
      chk(got, {8'h00, r[7:0]});
      chk({12'h000, role_c}, {12'h000, r[3:0]});
    end
    rd_reg(6'h3c);
    chk(got, 16'h0000);
    wr_reg(6'h00, 16'h0000);
    wr_reg(6'h14, 16'h0040);
    for (i = 1; i < 8; i = i + 1) begin
      c = i[3:0];
      wr_reg(6'h04, {8'h00, c, 4'h0});
      cnt <= 16'h0030;
      tick(3);
      chk({15'h0, pb_oe_n}, {15'h0, c[1:0] == 2'h0});
      if (c[1:0] != 2'h0) chk({15'h0, pb_o}, {15'h0, c[2]});
      wr_reg(6'h0c, 16'h0001);
      cnt <= 16'h0040;
      tick(4);
      if (c[1:0] != 2'h0) chk({15'h0, pb_o}, {15'h0, exp_pin(c)});
      chk({15'h0, st}, 16'h0001);
      wr_reg(6'h0c, 16'h0000);
      tick(3);
      if (c[1:0] != 2'h0) chk({15'h0, pb_o}, {15'h0, c[2]});
    end
    wr_reg(6'h04, 16'h0000);
    ext_en <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 8; i = i + 1) begin
      c = {2'b10, i[1:0]};
      r = $random(seed);
      if (i < 4) wr_reg(6'h04, {8'h00, c, 4'h0});
      else wr_reg(6'h00, {8'h00, c, 4'h0});
      wr_reg(i < 4 ? 6'h14 : 6'h1c, 16'h0000);
      cnt <= r[15:0];
      lvl_b <= 1'b1;
      lvl_d <= 1'b1;
      repeat (6) @(posedge clk);
      cnt <= r[31:16];
      lvl_b <= 1'b0;
      lvl_d <= 1'b0;
      repeat (6) @(posedge clk);
      rd_reg(i < 4 ? 6'h14 : 6'h1c);
      chk(got, (c[1:0] == 2'h0) ? r[15:0] : r[31:16]);
    end
    ext_en <= 1'b0;
    wr_reg(6'h04, 16'h00c0);
    wr_reg(6'h00, 16'h00c0);
    wr_reg(6'h24, 16'h0005);
    for (i = 0; i < 2; i = i + 1) begin
      wr_reg(6'h20, 16'h000f);
      wr_reg(6'h10, {15'h0, i[0]});
      wr_reg(6'h14, 16'h0000);
      wr_reg(6'h1c, 16'h0000);
      cnt <= 16'h0abc;
      ch1 <= 1'b1;
      @(posedge clk);
      ch1 <= 1'b0;
      tick(3);
      chk({15'h0, irq}, i[15:0]);
      chk({13'h0, psc}, {15'h0, i[0]});
      rd_reg(6'h14);
      chk(got, i ? 16'h0abc : 16'h0000);
      rd_reg(6'h1c);
      chk(got, i ? 16'h0abc : 16'h0000);
    end
    wr_reg(6'h20, 16'h000f);
    tick(0);
    chk({15'h0, irq}, 16'h0000);
    wr_reg(6'h08, 16'h0020);
    wr_reg(6'h00, 16'h0081);
    wr_reg(6'h1c, 16'h1234);
    ext_en <= 1'b1;
    lvl_d <= 1'b1;
    tick(6);
    chk({15'h0, pd_oe_n}, 16'h0001);
    rd_reg(6'h1c);
    chk(got, 16'h1234);
    rd_reg(6'h20);
    chk(got, 16'h0000);
    // Buffer pairing: a B capture must push the old B value into D
    @(posedge clk);
    cnt <= 16'h0555;
    ch1 <= 1'b1;
    @(posedge clk);
    ch1 <= 1'b0;
    tick(2);
    rd_reg(6'h14);
    chk(got, 16'h0555);
    rd_reg(6'h1c);
    chk(got, 16'h0abc);
    tally_and_finish;
  end
endmodule
